// >>> hdl/freq_prot_map.svh
// Constants for the four-stage frequency supervision block
`ifndef FREQ_PROT_MAP_SVH
`define FREQ_PROT_MAP_SVH
`define FP_STAGES 4
`define FP_FREQ_W 16
`define FP_VOLT_W 16
`define FP_TIME_W 32
`define FP_QUAL_COUNT 3'h5
`define FP_HYST_MHZ 16'h0014
`define FP_RANGE_LO_MHZ 16'h61A8
`define FP_RANGE_HI_MHZ 16'hFFFF
`define FP_RANGE_HI_FULL_MHZ 17'h11170
`define FP_VMIN_PCT 8'h41
`define FP_PCT_FULL 8'h64
`define FP_MODE_OFF 2'h0
`define FP_MODE_TRIP 2'h1
`define FP_MODE_ALARM 2'h2
`define FP_CLK_HZ 40000000
`define FP_PERIOD_NS 25
`endif

// >>> hdl/freq_prot_pkg.sv
// Types for the four-stage frequency supervision block
package freq_prot_pkg;
    typedef enum logic [1:0] {
        stage_off,
        stage_trip,
        stage_alarm
    } stage_mode_t;
    typedef struct packed {
        stage_mode_t mode;
        logic [15:0] threshold_mhz;
        logic [31:0] delay_cycles;
    } stage_cfg_t;
    typedef struct packed {
        logic [15:0] u12;
        logic [15:0] u23;
        logic [15:0] u31;
    } volt_set_t;
endpackage

// >>> hdl/freq_stage.sv
// One frequency stage: qualifier, dropout counter, delay timer, command hold
`timescale 1ns/1ps
`include "freq_prot_map.svh"
module freq_stage
    import freq_prot_pkg::*;
#(
    parameter int TIME_W = `FP_TIME_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire stage_cfg_t i_cfg,
    input wire logic [15:0] i_rated_mhz,
    input wire logic [15:0] i_freq_mhz,
    input wire logic i_eval,
    input wire logic i_force_drop,
    input wire logic [TIME_W-1:0] i_min_cmd_cycles,
    output logic o_pickup,
    output logic o_trip_signal,
    output logic o_trip_cmd
);
    logic is_over;
    logic active;
    logic beyond;
    logic inside_drop;
    logic [2:0] cnt;
    logic [TIME_W-1:0] timer;
    logic [TIME_W-1:0] hold;
    logic [16:0] drop_level;
    logic drop_now;

    // Direction follows threshold vs rated, equal means inactive
    assign is_over = i_cfg.threshold_mhz > i_rated_mhz;
    assign active = (i_cfg.mode != stage_off) && (i_cfg.threshold_mhz != i_rated_mhz);
    assign beyond = is_over ? (i_freq_mhz > i_cfg.threshold_mhz)
                            : (i_freq_mhz < i_cfg.threshold_mhz);
    // Dropout level offset by hysteresis, below for over, above for
    assign drop_level = is_over ? ({1'b0, i_cfg.threshold_mhz} - {1'b0, `FP_HYST_MHZ})
                                : ({1'b0, i_cfg.threshold_mhz} + {1'b0, `FP_HYST_MHZ});
    assign inside_drop = is_over ? ({1'b0, i_freq_mhz} < drop_level)
                                 : ({1'b0, i_freq_mhz} > drop_level);
    // Every cause that clears pickup at this edge, so the trip signal ends with it
    assign drop_now = i_force_drop || !active
                      || (i_eval && o_pickup && inside_drop && cnt == `FP_QUAL_COUNT - 3'h1);

    // Five consecutive agreeing measurements for pickup and dropout
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 3'h0;
            o_pickup <= 1'b0;
        end else if (i_force_drop || !active) begin
            cnt <= 3'h0; // Immediate dropout, no requalification
            o_pickup <= 1'b0;
        end else if (i_eval) begin
            if (!o_pickup) begin
                cnt <= beyond ? cnt + 3'h1 : 3'h0;
                if (beyond && cnt == `FP_QUAL_COUNT - 3'h1) begin
                    o_pickup <= 1'b1;
                    cnt <= 3'h0;
                end
            end else begin
                cnt <= inside_drop ? cnt + 3'h1 : 3'h0;
                if (inside_drop && cnt == `FP_QUAL_COUNT - 3'h1) begin
                    o_pickup <= 1'b0;
                    cnt <= 3'h0;
                end
            end
        end
    end

    // Delay timer started by pickup; trip signal ends at dropout
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer <= '0;
            o_trip_signal <= 1'b0;
        end else if (!o_pickup || drop_now) begin
            timer <= '0;
            o_trip_signal <= 1'b0;
        end else if (timer >= i_cfg.delay_cycles[TIME_W-1:0]) begin
            o_trip_signal <= (i_cfg.mode == stage_trip); // Alarm-only never trips
        end else begin
            timer <= timer + 1'b1;
        end
    end

    // Command held for the device-wide minimum duration
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold <= '0;
            o_trip_cmd <= 1'b0;
        end else if (o_trip_signal) begin
            hold <= '0;
            o_trip_cmd <= 1'b1;
        end else if (o_trip_cmd && hold + 1'b1 < i_min_cmd_cycles) begin
            hold <= hold + 1'b1;
        end else begin
            o_trip_cmd <= 1'b0;
            hold <= '0;
        end
    end

    chk_alarm_no_trip: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.mode != stage_trip) |=> !o_trip_signal)
        else $error("trip signal in alarm-only or off mode");
    chk_equal_inactive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.threshold_mhz == i_rated_mhz) |=> !o_pickup)
        else $error("stage with rated threshold picked up");
    chk_force_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_force_drop |=> !o_pickup && !o_trip_signal)
        else $error("forced dropout not immediate");
    chk_pickup_qual: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_pickup) |-> $past(i_eval) && $past(cnt) == 3'h4)
        else $error("pickup without five measurements");
    chk_trip_needs_pu: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_trip_signal |-> o_pickup)
        else $error("trip signal without pickup");
    chk_cmd_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_trip_signal |=> o_trip_cmd)
        else $error("trip command not asserted");
endmodule // freq_stage

// >>> hdl/freq_prot.sv
// Four-stage frequency supervision top level
// Notes on behaviour
// - Four stages, own threshold, delay, direction
// - Threshold above rated is over, below under
// - Threshold equal to rated never picks up
// - Measure on largest phase-to-phase voltage
// - No measurement below 65 percent nominal
// - Flag undervoltage block when all low
// - Voltage loss after pickup drops stage
// - Discard results followed by sign reversal
// - Dropout offset twenty millihertz inside threshold
// - Pickup after five beyond-threshold half-period samples
// - Outside 25 to 70 Hz all drop
// - Resume only when voltage also in range
// - Voltage switched off drops immediately
// - Ready at once when voltage appears
// - Pickup starts timer, expiry gives trip
// - Dropout after five absent-condition measurements
// - Trip ends at dropout, command held minimum
// - Per-stage block acts immediately
// - Global block disables all stages
// - Mode off, trip, or alarm only
`timescale 1ns/1ps
`include "freq_prot_map.svh"
module freq_prot
    import freq_prot_pkg::*;
#(
    parameter int STAGES = `FP_STAGES,
    parameter int TIME_W = `FP_TIME_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [15:0] i_rated_mhz,
    input wire logic [15:0] i_nominal_volt,
    input wire volt_set_t i_volt,
    input wire logic [15:0] i_freq_mhz,
    input wire logic i_freq_valid,
    input wire stage_cfg_t [STAGES-1:0] i_stage_cfg,
    input wire logic [TIME_W-1:0] i_min_cmd_cycles,
    input wire logic [STAGES-1:0] i_block_stage,
    input wire logic i_block_all,
    output logic [STAGES-1:0] o_pickup,
    output logic [STAGES-1:0] o_trip_signal,
    output logic [STAGES-1:0] o_trip_cmd,
    output logic o_freq_undervoltage_blocked,
    output logic o_measuring
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for the binary blocking inputs
    logic [STAGES:0] blk_meta;
    logic [STAGES:0] blk_sync;

    // Blocking inputs come from pins, so they are synchronised first
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            blk_meta <= '0;
            blk_sync <= '0;
        end else begin
            blk_meta <= {i_block_all, i_block_stage};
            blk_sync <= blk_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Voltage selection and supervision
    function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] c);
        logic [15:0] m;
        m = (a > b) ? a : b;
        max3 = (m > c) ? m : c;
    endfunction

    function automatic logic below_min(input logic [15:0] v, input logic [15:0] nom);
        below_min = ({8'h00, v} * {16'h0000, `FP_PCT_FULL})
                    < ({8'h00, nom} * {16'h0000, `FP_VMIN_PCT});
    endfunction

    logic [15:0] vsel;
    logic volt_low;
    logic all_low;
    logic freq_in_range;

    assign vsel = max3(i_volt.u12, i_volt.u23, i_volt.u31); // Automatic pick
    assign volt_low = below_min(vsel, i_nominal_volt);
    assign all_low = below_min(i_volt.u12, i_nominal_volt) && below_min(i_volt.u23, i_nominal_volt)
                     && below_min(i_volt.u31, i_nominal_volt);
    // 70 Hz does not fit the word, so the upper check is done at 17 bits
    assign freq_in_range = (i_freq_mhz >= `FP_RANGE_LO_MHZ)
                           && ({1'b0, i_freq_mhz} <= `FP_RANGE_HI_FULL_MHZ);

    // Undervoltage indication registered straight to the port
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_freq_undervoltage_blocked <= 1'b0;
        end else begin
            o_freq_undervoltage_blocked <= all_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase-jump filter on the sign of the frequency change
    logic [15:0] last_freq;
    logic [1:0] last_sign;
    logic [1:0] cur_sign;
    logic have_last;
    logic [15:0] held_freq;
    logic held_ok;
    logic eval_pulse;
    logic sign_flip;

    assign cur_sign = (i_freq_mhz > last_freq) ? 2'h1 : (i_freq_mhz < last_freq) ? 2'h2 : 2'h0;
    assign sign_flip = have_last && (cur_sign != 2'h0) && (last_sign != 2'h0)
                       && (cur_sign != last_sign);

    // One sample delay so a result can be thrown out when the next reverses
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_freq <= 16'h0000;
            last_sign <= 2'h0;
            have_last <= 1'b0;
            held_freq <= 16'h0000;
            held_ok <= 1'b0;
            eval_pulse <= 1'b0;
        end else begin
            eval_pulse <= 1'b0;
            if (volt_low) begin
                have_last <= 1'b0; // Fresh start when voltage returns
                held_ok <= 1'b0;
                last_sign <= 2'h0;
            end else if (i_freq_valid) begin // Only on valid strobes
                last_freq <= i_freq_mhz;
                last_sign <= cur_sign;
                have_last <= 1'b1;
                held_freq <= last_freq; // Prior sample waits for the verdict on this one
                held_ok <= freq_in_range;
                // Previous sample released only if not followed by a reversal
                eval_pulse <= have_last && !sign_flip && held_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Measurement status and dropout causes
    logic force_common;
    logic [15:0] eval_freq;

    // Stored value feeds stages; it lags the strobe by one half period
    assign eval_freq = held_freq;
    assign force_common = volt_low || blk_sync[STAGES]
                          || (i_freq_valid && !freq_in_range);

    // Measuring only with voltage and frequency both in range
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_measuring <= 1'b0;
        end else if (volt_low || (i_freq_valid && !freq_in_range)) begin
            o_measuring <= 1'b0;
        end else if (i_freq_valid) begin
            o_measuring <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The four stages
    logic [STAGES-1:0] pu_w;
    logic [STAGES-1:0] ts_w;
    logic [STAGES-1:0] tc_w;

    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            // Independent threshold, delay and mode per stage
            freq_stage #(
                .TIME_W(TIME_W)
            ) u_stage (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(i_rst_n),
                .i_cfg(i_stage_cfg[g]),
                .i_rated_mhz(i_rated_mhz),
                .i_freq_mhz(eval_freq),
                .i_eval(eval_pulse && o_measuring),
                .i_force_drop(force_common || blk_sync[g]),
                .i_min_cmd_cycles(i_min_cmd_cycles),
                .o_pickup(pu_w[g]),
                .o_trip_signal(ts_w[g]),
                .o_trip_cmd(tc_w[g])
            );
        end
    endgenerate

    // Stage outputs pass through one more register to the ports
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pickup <= '0;
            o_trip_signal <= '0;
            o_trip_cmd <= '0;
        end else begin
            o_pickup <= pu_w;
            o_trip_signal <= ts_w;
            o_trip_cmd <= tc_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_global_block: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        blk_sync[STAGES] |=> ##1 (o_pickup == '0))
        else $error("global block did not drop stages");
    chk_volt_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        volt_low |=> ##1 (o_pickup == '0) && (o_trip_signal == '0))
        else $error("voltage loss did not drop stages");
    chk_range_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_freq_valid && !freq_in_range) |=> ##1 (o_pickup == '0))
        else $error("out of range frequency kept pickup");
    chk_uv_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        all_low |=> o_freq_undervoltage_blocked)
        else $error("undervoltage flag missing");
    chk_no_eval_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        volt_low |=> !eval_pulse && !o_measuring)
        else $error("evaluation while voltage below minimum");
    chk_flip_discard: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_freq_valid && sign_flip) |=> !eval_pulse)
        else $error("sample before sign reversal not discarded");
    chk_eval_strobe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        eval_pulse |-> $past(i_freq_valid))
        else $error("evaluation without strobe");
    chk_stage_block: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        blk_sync[0] |=> ##1 !o_pickup[0])
        else $error("stage block not immediate");
endmodule // freq_prot

// >>> bench/fp_front_end.sv
// Behavioural voltage front end and blocking source facing the frequency block
`timescale 1ns/1ps
module fp_front_end
    import freq_prot_pkg::*;
#(
    parameter int HALF = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [15:0] i_freq_set,
    input wire volt_set_t i_volt_set,
    input wire logic i_swing,
    output volt_set_t o_volt,
    output logic [15:0] o_freq_mhz,
    output logic o_freq_valid,
    output logic o_block_all
);
    logic [7:0] cnt;

    ////////////////////////////////////////////////////////////////////////////
    // One strobe per shortened half period; word is junk between strobes
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 8'h00;
            o_freq_valid <= 1'b0;
            o_freq_mhz <= 16'h0000;
        end else if (i_run && cnt == 8'(HALF - 1)) begin
            cnt <= 8'h00;
            o_freq_valid <= 1'b1;
            o_freq_mhz <= i_freq_set;
        end else begin
            cnt <= i_run ? cnt + 8'h01 : 8'h00;
            o_freq_valid <= 1'b0;
            o_freq_mhz <= ~o_freq_mhz; // Stale word must not look valid
        end
    end

    // Magnitudes pass straight through, same clock domain
    assign o_volt = i_volt_set;
    // Swing detector forces the global block
    assign o_block_all = i_swing;
endmodule // fp_front_end

// >>> bench/test_four_stage_frequency_protection.sv
// Self-checking bench for the four-stage frequency supervision block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t got %h expected %h", $time, a, e); end end
module test_four_stage_frequency_protection;
    import freq_prot_pkg::*;
    logic clk, rst_n, run, swing, fv, uvb, meas;
    logic [15:0] freq_set, fw;
    volt_set_t volt_set, vw;
    logic blk_all;
    stage_cfg_t [3:0] cfg;
    logic [3:0] blk, pick, tsig, tcmd;
    int fail_count = 0;
    int checks_done = 0;

    fp_front_end #(.HALF(8)) i_fp_front_end (.i_clk_sys(clk), .i_rst_n(rst_n), .i_run(run),
        .i_freq_set(freq_set), .i_volt_set(volt_set), .i_swing(swing), .o_volt(vw),
        .o_freq_mhz(fw), .o_freq_valid(fv), .o_block_all(blk_all));
    freq_prot i_freq_prot (.i_clk_sys(clk), .i_rst_n(rst_n), .i_rated_mhz(16'hC350),
        .i_nominal_volt(16'h0064), .i_volt(vw), .i_freq_mhz(fw), .i_freq_valid(fv),
        .i_stage_cfg(cfg), .i_min_cmd_cycles(32'h00000190), .i_block_stage(blk),
        .i_block_all(blk_all), .o_pickup(pick), .o_trip_signal(tsig), .o_trip_cmd(tcmd),
        .o_freq_undervoltage_blocked(uvb), .o_measuring(meas));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Ends on the falling edge so outputs are settled when read
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Counts strobes off the edge; a silent model counts as a mismatch
    task automatic strobes(input int n);
        int k;
        k = 0;
        for (int i = 0; i < 16 * n && k < n; i++) begin
            @(negedge clk);
            if (fv === 1'b1) k++;
        end
        if (k < n) begin
            $display("unexpected at %0t got %h expected %h", $time, k, n);
            fail_count++;
            stop_test();
        end
    endtask

    // Bounded wait on pickup (0), trip command (1) or undervoltage flag (2)
    task automatic wait_for(input int sel, input int s, input logic lvl, input int lim);
        logic v;
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            v = (sel == 0) ? pick[s] : (sel == 1) ? tcmd[s] : uvb;
            if (v === lvl) return;
        end
        $display("unexpected at %0t got %h expected %h", $time, ~lvl, lvl);
        fail_count++;
        stop_test();
    endtask

    task automatic freq(input logic [15:0] f);
        @(posedge clk);
        freq_set <= f;
    endtask

    task automatic volts(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clk);
        volt_set <= '{a, b, c};
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_pickup_trip();
        `CHK({pick, tsig, tcmd, uvb, meas}, 14'h0000)
        freq(16'hBB80);
        tick(100);
        `CHK(pick, 4'h0)
        @(posedge clk);
        run <= 1'b1;
        strobes(4);
        tick(2);
        `CHK(pick, 4'h0)
        wait_for(0, 0, 1'b1, 100);
        `CHK(pick[3:1], 3'h0)
        tick(40);
        `CHK(tcmd[0], 1'b0)
        wait_for(1, 0, 1'b1, 60);
        $display("test pickup_trip done");
    endtask

    task automatic t_dropout_hold();
        freq(16'hC350);
        strobes(4);
        `CHK(pick[0], 1'b1)
        wait_for(0, 0, 1'b0, 40);
        tick(3);
        `CHK(tsig[0], 1'b0)
        `CHK(tcmd[0], 1'b1)
        wait_for(1, 0, 1'b0, 600);
        $display("test dropout_hold done");
    endtask

    task automatic t_hysteresis();
        freq(16'hBB80);
        wait_for(0, 0, 1'b1, 100);
        freq(16'hBF72);
        strobes(8);
        `CHK(pick[0], 1'b1)
        freq(16'hBF86);
        wait_for(0, 0, 1'b0, 80);
        $display("test hysteresis done");
    endtask

    task automatic t_over_alarm();
        freq(16'hC92C);
        wait_for(0, 1, 1'b1, 100);
        tick(200);
        `CHK({tsig[1], tcmd[1], pick[2], pick[0]}, 4'h0)
        $display("test over_alarm done");
    endtask

    task automatic t_voltage();
        volts(16'h0040, 16'h0040, 16'h0040);
        wait_for(0, 1, 1'b0, 6);
        wait_for(2, 0, 1'b1, 6);
        strobes(8);
        `CHK({pick, meas}, 5'h00)
        volts(16'h0000, 16'h0000, 16'h0041);
        wait_for(0, 1, 1'b1, 100);
        `CHK(uvb, 1'b0)
        volts(16'h0000, 16'h0000, 16'h0040);
        wait_for(0, 1, 1'b0, 6);
        volts(16'h0064, 16'h0064, 16'h0064);
        wait_for(0, 1, 1'b1, 100);
        $display("test voltage done");
    endtask

    task automatic t_range();
        freq(16'h5DC0);
        wait_for(0, 1, 1'b0, 16);
        tick(2);
        `CHK({pick, meas}, 5'h00)
        volts(16'h0040, 16'h0040, 16'h0040);
        freq(16'hC92C);
        strobes(8);
        `CHK({pick, meas}, 5'h00)
        volts(16'h0064, 16'h0064, 16'h0064);
        wait_for(0, 1, 1'b1, 100);
        $display("test range done");
    endtask

    task automatic t_block();
        @(posedge clk);
        blk <= 4'h2;
        wait_for(0, 1, 1'b0, 6);
        strobes(8);
        `CHK(pick, 4'h0)
        @(posedge clk);
        blk <= 4'h0;
        wait_for(0, 1, 1'b1, 100);
        @(posedge clk);
        swing <= 1'b1;
        wait_for(0, 1, 1'b0, 6);
        strobes(8);
        `CHK(pick, 4'h0)
        @(posedge clk);
        swing <= 1'b0;
        $display("test block done");
    endtask

    // One reversed sample inside a run of beyond samples must not reset the count
    task automatic t_phase_jump();
        freq(16'hC350);
        strobes(8);
        freq(16'hBB80);
        strobes(4);
        `CHK(pick[0], 1'b0)
        freq(16'hC350);
        strobes(1);
        freq(16'hBB80);
        strobes(2);
        tick(3);
        `CHK(pick[0], 1'b1)
        $display("test phase_jump done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock and main sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        run = 1'b0;
        swing = 1'b0;
        blk = 4'h0;
        freq_set = 16'hC350;
        volt_set = '{16'h0064, 16'h0064, 16'h0064};
        // Under trip, over alarm-only, threshold at rated, off
        cfg[0] = '{stage_trip, 16'hBF68, 32'h0000003C};
        cfg[1] = '{stage_alarm, 16'hC738, 32'h0000003C};
        cfg[2] = '{stage_trip, 16'hC350, 32'h00000010};
        cfg[3] = '{stage_off, 16'hBB80, 32'h00000010};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        t_pickup_trip();
        t_dropout_hold();
        t_hysteresis();
        t_over_alarm();
        t_voltage();
        t_range();
        t_block();
        t_phase_jump();
        stop_test();
    end
endmodule // test_four_stage_frequency_protection
